// ===== hdl/itp_defines.svh
`ifndef ITP_DEFINES_SVH
`define ITP_DEFINES_SVH

// bus address of this target, 7 bits
`define ITP_TARGET_ADDR 7'h6b
// direction bit value that asks for data
`define ITP_DIR_READ    1'b1
// answer to a read of an unmapped byte address
`define ITP_UNMAPPED    8'hff
// storage covers byte addresses 0 .. depth-1
`define ITP_MAP_DEPTH   100
// bit counter: last data bit and acknowledge slot
`define ITP_BIT_LAST    4'h7
`define ITP_BIT_ACK     4'h8
// counter value after a start: the fall that ends it wraps to zero
`define ITP_BIT_PRE     4'hf

// system clock rate
`define ITP_CLK_HZ      10000000
// stuck transaction timeout, in milliseconds
`define ITP_TMO_MS      2000
// timeout in system clocks, rounded down
`define ITP_TMO_CYC     (`ITP_TMO_MS * (`ITP_CLK_HZ / 1000))
// least clock stretch after each byte, in ns
`define ITP_STRETCH_NS  300
// stretch in system clocks, rounded up
`define ITP_STRETCH_CYC \
    ((`ITP_STRETCH_NS * (`ITP_CLK_HZ / 1000000) + 999) / 1000)

`endif

// ===== hdl/itp_pkg.sv
package itp_pkg;

    // byte on the wire and in the map
    typedef logic [7:0] itp_byte_t;

    // protocol state, gray along idle-dev-reg-wr and rd-skip-idle
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,   // bus free or not ours
        ST_DEV  = 3'b001,   // receiving target address
        ST_REG  = 3'b011,   // receiving register address
        ST_WR   = 3'b010,   // receiving data bytes
        ST_RD   = 3'b110,   // sending data bytes
        ST_SKIP = 3'b100    // wait for stop or repeated start
    } itp_state_t;

    // byte addresses that belong to the register map
    function automatic logic itp_mapped(input itp_byte_t a);
        itp_mapped = a inside {[8'h02:8'h0d], 8'h15, [8'h17:8'h19],
                               [8'h1b:8'h1e], [8'h21:8'h34],
                               [8'h37:8'h38], [8'h3b:8'h3d],
                               [8'h62:8'h63]};
    endfunction : itp_mapped

    // low byte of a two byte register
    function automatic logic itp_wide_low(input itp_byte_t a);
        itp_wide_low = a inside {8'h02, 8'h04, 8'h06, 8'h08, 8'h0a,
                                 8'h0c, 8'h2d, 8'h2f, 8'h31, 8'h33,
                                 8'h37, 8'h62};
    endfunction : itp_wide_low

endpackage : itp_pkg

// ===== hdl/itp_regmap.sv
`timescale 1ns/100ps
`include "itp_defines.svh"

module itp_regmap
    import itp_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire logic      ce,
    input  wire logic      wr_stb,
    input  wire itp_byte_t wr_addr,
    input  wire itp_byte_t wr_data,
    input  wire itp_byte_t rd_addr,
    output itp_byte_t      rd_data
);

    itp_byte_t mem [0:`ITP_MAP_DEPTH-1]; // byte storage
    logic      stage_vld;                // low byte waiting
    itp_byte_t stage_addr;               // its address
    itp_byte_t stage_data;               // its value

    // low byte of a wide register waits for its partner
    wire       wr_low    = wr_stb & itp_wide_low(wr_addr);
    wire       wr_plain  = wr_stb & ~itp_wide_low(wr_addr);
    wire       commit_hi = wr_plain & stage_vld &
                           (wr_addr == stage_addr + 8'h01);

    // staging keeps a half written value off the converter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage_vld  <= 1'b0;
            stage_addr <= 8'h00;
            stage_data <= 8'h00;
        end else if (ce) begin
            if (wr_low) begin // R5
                stage_vld  <= 1'b1;
                stage_addr <= wr_addr;
                stage_data <= wr_data;
            end else if (wr_plain) begin
                stage_vld  <= 1'b0;
            end
        end
    end

    // one byte cell per address
    genvar i;
    generate
        for (i = 0; i < `ITP_MAP_DEPTH; i++) begin : g_cell
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    mem[i] <= 8'h00;
                end else if (ce) begin
                    if (wr_plain && wr_addr == 8'(i)) begin
                        mem[i] <= wr_data;
                    end
                    if (commit_hi && stage_addr == 8'(i)) begin // R5
                        mem[i] <= stage_data;
                    end
                end
            end
        end
    endgenerate

    // unmapped bytes read as all ones
    assign rd_data = itp_mapped(rd_addr) ? mem[rd_addr[6:0]]
                                         : `ITP_UNMAPPED; // R3

endmodule : itp_regmap

// ===== hdl/itp_i2c_target.sv
// Summary of operation
// R1: answer only target address 0x6b
// R2: direction bit zero writes, one reads
// R3: unmapped register reads return 0xff
// R4: runs at 100k, 400k, 1M bit rates
// R5: wide registers little endian, high byte above
// R6: controller writes both wide bytes in order
// R7: data changes only while clock low
// R8: start and stop seen with clock high
// R9: bus busy from start until stop
// R10: two second stuck start resets, releases lines
// R11: eight bits msb first plus acknowledge
// R12: any number of bytes per transfer
// R13: target may hold clock low between bytes
// R14: controller makes every clock pulse
// R15: receiver pulls data low on ninth clock
// R16: high on ninth clock is not acknowledge
// R17: single write: address, register, data, stop
// R18: undefined register address gets nack, idle
// R19: multi byte reads and writes everywhere
// R20: register pointer advances after each byte
`timescale 1ns/100ps
`include "itp_defines.svh"

module itp_i2c_target
    import itp_pkg::*;
#(
    parameter int unsigned TMO_CYC = `ITP_TMO_CYC
)
(
    input  wire logic       CLK_SYS,
    input  wire logic       RST_N,
    input  wire logic       CE,
    input  wire logic       SCL_I,
    input  wire logic       SDA_I,
    output logic            SCL_O,
    output logic            SCL_OE,
    output logic            SDA_O,
    output logic            SDA_OE,
    output logic            BUSY,
    output logic            WR_STB,
    output logic [7:0]      WR_ADDR,
    output logic [7:0]      WR_DATA
);

    localparam logic [1:0]  STRETCH = 2'(`ITP_STRETCH_CYC);
    localparam logic [24:0] TMO_TOP = 25'(TMO_CYC - 1);

    // pin synchronisers and delayed copies
    logic        scl_s1;      // first stage, read by scl_s2 only
    logic        scl_s2;      // clean clock level
    logic        scl_d;       // previous clean level
    logic        sda_s1;      // first stage, read by sda_s2 only
    logic        sda_s2;      // clean data level
    logic        sda_d;       // previous clean level

    // protocol state
    itp_state_t  state;       // where in the frame we are
    logic [3:0]  bit_idx;     // 0..7 data, 8 acknowledge
    itp_byte_t   rx;          // incoming shift register
    itp_byte_t   tx;          // outgoing shift register
    itp_byte_t   ptr;         // register pointer
    logic        rw;          // latched direction bit
    logic [1:0]  stretch;     // clock hold countdown
    logic [24:0] tmo_cnt;     // time since start

    // next values
    itp_state_t  next_state;
    logic [3:0]  next_bit;
    itp_byte_t   next_tx;
    itp_byte_t   next_ptr;
    logic        next_rw;
    logic        next_sda_oe;
    logic        next_wr;
    itp_byte_t   next_wr_addr;
    itp_byte_t   next_wr_data;
    logic [1:0]  next_stretch;
    logic        next_busy;

    itp_byte_t   rd_data;     // map byte at the pointer

    // sampling at 10 MHz leaves at least two samples per
    // clock phase even at the fastest bit rate
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d  <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d  <= 1'b1;
        end else if (CE) begin
            scl_s1 <= SCL_I; // R4
            scl_s2 <= scl_s1;
            scl_d  <= scl_s2;
            sda_s1 <= SDA_I;
            sda_s2 <= sda_s1;
            sda_d  <= sda_s2;
        end
    end

    // line events, all from the clean copies
    wire scl_rise   = scl_s2 & ~scl_d;
    wire scl_fall   = ~scl_s2 & scl_d;
    wire scl_high   = scl_s2 & scl_d;
    wire start_cond = scl_high & sda_d & ~sda_s2; // R8
    wire stop_cond  = scl_high & ~sda_d & sda_s2; // R8

    // frame level decodes
    wire active     = (state != ST_IDLE) && (state != ST_SKIP);
    wire tmo_hit    = BUSY && (tmo_cnt >= TMO_TOP); // R10
    wire bit_data   = bit_idx <= `ITP_BIT_LAST;
    wire bit_last   = bit_idx == `ITP_BIT_LAST;
    wire bit_ack    = bit_idx == `ITP_BIT_ACK;
    wire bit_pre    = bit_idx == `ITP_BIT_PRE; // clock low after start
    wire addr_hit   = rx[7:1] == `ITP_TARGET_ADDR; // R1
    wire reg_ok     = itp_mapped(rx); // R18
    wire ptr_ok     = itp_mapped(ptr);
    wire nack_seen  = scl_rise && bit_ack && state == ST_RD
                      && sda_s2; // R16
    wire ack_end    = scl_fall && bit_ack && active;

    // bus busy between start and stop
    assign next_busy = tmo_hit    ? 1'b0 :
                       start_cond ? 1'b1 :
                       stop_cond  ? 1'b0 : BUSY; // R9

    // stretch after each acknowledge so the next bit has
    // its setup time before the controller raises the clock
    assign next_stretch =
        (tmo_hit || start_cond || stop_cond) ? 2'b00 :
        ack_end                 ? STRETCH :        // R13
        (stretch != 2'b00)      ? stretch - 2'b01 : 2'b00;

    // byte and bit sequencing
    always_comb begin
        next_state   = state;
        next_bit     = bit_idx;
        next_tx      = tx;
        next_ptr     = ptr;
        next_rw      = rw;
        next_sda_oe  = SDA_OE;
        next_wr      = 1'b0;
        next_wr_addr = WR_ADDR;
        next_wr_data = WR_DATA;
        if (tmo_hit) begin
            // stuck frame: drop everything, free the lines
            next_state  = ST_IDLE; // R10
            next_sda_oe = 1'b0;
        end else if (start_cond) begin
            // also a repeated start; pointer is kept
            next_state  = ST_DEV; // R2
            // the clock fall that closes a start carries no bit
            next_bit    = `ITP_BIT_PRE; // R8
            next_sda_oe = 1'b0;
        end else if (stop_cond) begin
            next_state  = ST_IDLE;
            next_sda_oe = 1'b0;
        end else if (!active) begin
            // not addressed: keep off the data line
            next_sda_oe = 1'b0;
        end else if (nack_seen) begin
            // controller refuses more data
            next_state  = ST_SKIP; // R16
        end else if (scl_fall && (bit_pre || bit_idx < `ITP_BIT_LAST)) begin
            // mid byte: step, and present next bit if sending
            next_bit = bit_idx + 4'h1; // R11
            if (state == ST_RD) begin
                next_tx     = {tx[6:0], 1'b0};
                next_sda_oe = ~tx[6]; // R7
            end
        end else if (scl_fall && bit_last) begin
            // eighth bit done: decide the acknowledge
            next_bit = `ITP_BIT_ACK;
            unique case (state)
                ST_DEV: begin
                    if (addr_hit) begin
                        next_rw     = rx[0]; // R2
                        next_sda_oe = 1'b1; // R15
                    end else begin
                        next_state  = ST_SKIP; // R1
                        next_sda_oe = 1'b0;
                    end
                end
                ST_REG: begin
                    if (reg_ok) begin
                        next_ptr    = rx; // R17
                        next_sda_oe = 1'b1; // R15
                    end else begin
                        next_state  = ST_IDLE; // R18
                        next_sda_oe = 1'b0;
                    end
                end
                ST_WR: begin
                    // unmapped bytes inside a burst are dropped
                    next_wr      = ptr_ok; // R19
                    // address and data hold until the next real write
                    if (ptr_ok) begin
                        next_wr_addr = ptr;
                        next_wr_data = rx;
                    end
                    next_ptr     = ptr + 8'h01; // R20
                    next_sda_oe  = 1'b1; // R15
                end
                ST_RD: begin
                    // release so the controller can answer
                    next_sda_oe  = 1'b0; // R15
                end
            endcase
        end else if (ack_end) begin
            // acknowledge slot over: start next byte
            next_bit    = 4'h0; // R12
            next_sda_oe = 1'b0;
            unique case (state)
                ST_DEV: begin
                    if (rw == `ITP_DIR_READ) begin
                        next_state  = ST_RD; // R2
                        next_tx     = rd_data;
                        next_ptr    = ptr + 8'h01; // R20
                        next_sda_oe = ~rd_data[7]; // R11
                    end else begin
                        next_state  = ST_REG;
                    end
                end
                ST_REG: next_state = ST_WR; // R17
                ST_WR:  next_state = ST_WR; // R12
                ST_RD: begin
                    next_tx     = rd_data; // R19
                    next_ptr    = ptr + 8'h01; // R20
                    next_sda_oe = ~rd_data[7]; // R11
                end
            endcase
        end
    end

    // incoming bits, msb first, sampled on the clock rise
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            rx <= 8'h00;
        end else if (CE && active && scl_rise && bit_data) begin
            rx <= {rx[6:0], sda_s2}; // R11
        end
    end

    // time since start; a stop, a new start or the timeout clears it
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            tmo_cnt <= 25'h0000000;
        end else if (CE) begin
            if (!BUSY || start_cond || tmo_hit) begin
                tmo_cnt <= 25'h0000000;
            end else begin
                tmo_cnt <= tmo_cnt + 25'h0000001; // R10
            end
        end
    end

    // protocol registers
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            state   <= ST_IDLE;
            bit_idx <= 4'h0;
            tx      <= 8'h00;
            ptr     <= 8'h00;
            rw      <= 1'b0;
            stretch <= 2'b00;
        end else if (CE) begin
            state   <= next_state;
            bit_idx <= next_bit;
            tx      <= next_tx;
            ptr     <= next_ptr;
            rw      <= next_rw;
            stretch <= next_stretch;
        end
    end

    // pin and user outputs, all from flops
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            SCL_O   <= 1'b0;
            SCL_OE  <= 1'b0;
            SDA_O   <= 1'b0;
            SDA_OE  <= 1'b0;
            BUSY    <= 1'b0;
            WR_STB  <= 1'b0;
            WR_ADDR <= 8'h00;
            WR_DATA <= 8'h00;
        end else if (CE) begin
            SCL_O   <= 1'b0; // open drain: only ever pulls low
            SCL_OE  <= next_stretch != 2'b00; // R13
            SDA_O   <= 1'b0;
            SDA_OE  <= next_sda_oe; // R7
            BUSY    <= next_busy; // R9
            WR_STB  <= next_wr;
            WR_ADDR <= next_wr_addr;
            WR_DATA <= next_wr_data;
        end
    end

    // register storage; writes come from the strobe flops
    itp_regmap u_map (
        .clk     (CLK_SYS),
        .rst_n   (RST_N),
        .ce      (CE),
        .wr_stb  (WR_STB),
        .wr_addr (WR_ADDR),
        .wr_data (WR_DATA),
        .rd_addr (ptr),
        .rd_data (rd_data)
    );

endmodule : itp_i2c_target

// ===== tb/itp_chk.sv
`timescale 1ns/100ps
module itp_chk
    import itp_pkg::*;
#(
    parameter int unsigned TMO_CYC = 2000
)
(
    input wire logic       CLK_SYS,
    input wire logic       RST_N,
    input wire logic       CE,
    input wire logic       SCL_I,
    input wire logic       SDA_I,
    input wire logic       SCL_O,
    input wire logic       SCL_OE,
    input wire logic       SDA_O,
    input wire logic       SDA_OE,
    input wire logic       BUSY,
    input wire logic       WR_STB,
    input wire logic [7:0] WR_ADDR,
    input wire logic [7:0] WR_DATA
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    int unsigned busy_cnt; // busy cycles since the last start on the pins

    // a repeated start rearms the limit, so restart the count there too
    always_ff @(posedge CLK_SYS) begin
        busy_cnt <= (!BUSY || ($fell(SDA_I) && SCL_I && $past(SCL_I))) ?
                    0 : busy_cnt + 1;
    end

    tmo_bound_a: assert property (busy_cnt <= TMO_CYC + 16)
        else $error("busy outlived the stuck start limit");
    busy_start_a: assert property ($fell(SDA_I) && SCL_I &&
        $past(SCL_I) |-> ##[1:8] BUSY) else $error("start not seen");
    busy_stop_a: assert property ($rose(SDA_I) && SCL_I &&
        $past(SCL_I) |-> ##[1:8] !BUSY) else $error("stop not seen");
    stb_on_ack_a: assert property (WR_STB |-> SDA_OE && !SCL_I)
        else $error("write strobe outside an acknowledge");
    stb_pulse_a: assert property (WR_STB |=> !WR_STB)
        else $error("write strobe longer than one cycle");
    wr_hold_a: assert property (WR_ADDR != $past(WR_ADDR) ||
        WR_DATA != $past(WR_DATA) |-> WR_STB)
        else $error("write address or data moved without strobe");
    idle_release_a: assert property (!BUSY |-> !SDA_OE && !SCL_OE)
        else $error("line pulled while bus free");
    stretch_len_a: assert property ($rose(SCL_OE) |->
        SCL_OE [*3] ##1 !SCL_OE) else $error("stretch length wrong");
    stretch_busy_a: assert property ($rose(SCL_OE) |-> BUSY && !SCL_I)
        else $error("stretch outside a byte gap");
    sda_low_clk_a: assert property ($changed(SDA_OE) |-> !SCL_I)
        else $error("data line moved while clock high");
endmodule : itp_chk

bind itp_i2c_target itp_chk #(.TMO_CYC(TMO_CYC)) itp_chk_i (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(CE), .SCL_I(SCL_I),
    .SDA_I(SDA_I), .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_O(SDA_O),
    .SDA_OE(SDA_OE), .BUSY(BUSY), .WR_STB(WR_STB),
    .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA)
);

// ===== tb/itp_ctl_model.sv
`timescale 1ns/100ps
module itp_ctl_model (
    input  wire logic clk,
    input  wire logic scl,     // resolved wire levels
    input  wire logic sda,
    output logic      scl_low, // high pulls the line low
    output logic      sda_low,
    output logic      hang     // target held the clock too long
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        hang    = 1'b0;
    end

    // steps of one system clock cycle each
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // release the clock, then wait out any stretch, bounded
    task automatic scl_up();
        int k;
        scl_low <= 1'b0;
        for (k = 0; k < 64 && scl !== 1'b1; k++) @(posedge clk);
        if (k == 64) hang <= 1'b1;
    endtask : scl_up

    // start or repeated start, from clock low or idle
    task automatic start_cond();
        sda_low <= 1'b0;
        tick(2);
        scl_up();
        tick(4);
        sda_low <= 1'b1;
        tick(4);
        scl_low <= 1'b1;
        tick(2);
    endtask : start_cond

    // stop, plus time for the target to see it
    task automatic stop_cond();
        sda_low <= 1'b1;
        tick(2);
        scl_up();
        tick(4);
        sda_low <= 1'b0;
        tick(8);
    endtask : stop_cond

    // data moves only while the clock is low
    task automatic bit_xfer(input logic b, output logic r);
        sda_low <= !b;
        tick(2);
        scl_up();
        tick(4);
        r = sda;
        scl_low <= 1'b1;
        tick(2);
    endtask : bit_xfer

    // line released in the ninth slot for the target's answer
    task automatic wr_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_xfer(v[i], r);
        bit_xfer(1'b1, r);
        ack = !r;
    endtask : wr_byte

    // last byte of a read is refused so the target lets go
    task automatic rd_byte(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) bit_xfer(1'b1, v[i]);
        bit_xfer(last, r);
    endtask : rd_byte
endmodule : itp_ctl_model

// ===== tb/itp_i2c_target_tb.sv
`timescale 1ns/100ps
module itp_i2c_target_tb;
    import itp_pkg::*;
    localparam int unsigned TMO = 2000; // short stuck-start limit
    logic       clk_sys = 1'b0;
    logic       rst_n   = 1'b0;
    logic       ce      = 1'b1;
    logic       scl_o, scl_oe, sda_o, sda_oe, busy, wr_stb;
    logic [7:0] wr_addr, wr_data;
    logic       c_scl, c_sda, c_hang; // controller pulls and hang flag
    wire        scl_w = !(scl_oe | c_scl); // open drain with pull-up
    wire        sda_w = !(sda_oe | c_sda);
    int         seed = 43611;
    int         miscompares = 0;
    int         samples_checked = 0;
    logic [7:0] shadow [256];    // expected map contents
    logic [15:0] wq [$];         // captured write strobes
`define CHK(got, exp) begin samples_checked++; \
    if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
    end end

    always #50 clk_sys = ~clk_sys;

    itp_i2c_target #(.TMO_CYC(TMO)) itp_i2c_target_i (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce), .SCL_I(scl_w),
        .SDA_I(sda_w), .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_O(sda_o),
        .SDA_OE(sda_oe), .BUSY(busy), .WR_STB(wr_stb),
        .WR_ADDR(wr_addr), .WR_DATA(wr_data));
    itp_ctl_model itp_ctl_model_i (.clk(clk_sys), .scl(scl_w),
        .sda(sda_w), .scl_low(c_scl), .sda_low(c_sda), .hang(c_hang));

    // log every write the design commits
    always @(posedge clk_sys) begin
        if (wr_stb === 1'b1) wq.push_back({wr_addr, wr_data});
    end
    // a stuck clock ends the run at once
    always @(posedge c_hang) begin
        miscompares++;
        report_and_stop();
    end

    // unmapped bytes read back as all ones
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        return (a inside {[8'h02:8'h0d], 8'h15, [8'h17:8'h19],
            [8'h1b:8'h1e], [8'h21:8'h34], [8'h37:8'h38],
            [8'h3b:8'h3d], [8'h62:8'h63]}) ? shadow[a] : 8'hff;
    endfunction : exp_rd

    task automatic send(input logic [7:0] v, input logic exp_ack);
        logic a;
        itp_ctl_model_i.wr_byte(v, a);
        `CHK(a, exp_ack)
    endtask : send

    // set pointer, repeated start, read n bytes, refuse the last
    task automatic read_at(input logic [7:0] a, input int n);
        logic [7:0] v;
        itp_ctl_model_i.start_cond();
        send({7'h6b, 1'b0}, 1'b1);
        send(a, 1'b1);
        itp_ctl_model_i.start_cond();
        send({7'h6b, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            itp_ctl_model_i.rd_byte(i == n - 1, v);
            `CHK(v, exp_rd(a + i[7:0]))
        end
        itp_ctl_model_i.stop_cond();
        `CHK({busy, sda_oe, scl_o, sda_o}, 4'h0)
    endtask : read_at

    task automatic report_and_stop();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        logic [6:0] a;
        logic [7:0] r, d, lo, hi;
        int         k;
        foreach (shadow[i]) shadow[i] = 8'h00;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        `CHK({busy, scl_oe, sda_oe, wr_stb}, 4'h0)
        // foreign addresses get no answer
        for (int i = 0; i < 3; i++) begin
            a = 7'($random(seed));
            if (a == 7'h6b) a = 7'h6a;
            itp_ctl_model_i.start_cond();
            send({a, 1'b0}, 1'b0);
            itp_ctl_model_i.stop_cond();
        end
        // random single writes to plain registers
        for (int i = 0; i < 4; i++) begin
            r = 8'h21 + 8'($unsigned($random(seed)) % 12);
            d = 8'($random(seed));
            wq.delete();
            itp_ctl_model_i.start_cond();
            send({7'h6b, 1'b0}, 1'b1);
            `CHK(busy, 1'b1)
            send(r, 1'b1);
            send(d, 1'b1);
            itp_ctl_model_i.stop_cond();
            shadow[r] = d;
            `CHK({wq.size() == 1, wq[0]}, {1'b1, r, d})
        end
        read_at(8'h21, 12);
        // wide register in one burst, running into an unmapped byte
        lo = 8'($random(seed));
        hi = 8'($random(seed));
        itp_ctl_model_i.start_cond();
        send({7'h6b, 1'b0}, 1'b1);
        send(8'h0c, 1'b1);
        send(lo, 1'b1);
        send(hi, 1'b1);
        send(8'h5a, 1'b1);
        itp_ctl_model_i.stop_cond();
        shadow[8'h0c] = lo;
        shadow[8'h0d] = hi;
        read_at(8'h0c, 4);
        // undefined register address is refused
        itp_ctl_model_i.start_cond();
        send({7'h6b, 1'b0}, 1'b1);
        send(8'h00, 1'b0);
        `CHK(sda_oe, 1'b0)
        itp_ctl_model_i.stop_cond();
        // start left hanging with the clock held low
        itp_ctl_model_i.start_cond();
        send({7'h6b, 1'b0}, 1'b1);
        for (k = 0; k < TMO + 100 && busy === 1'b1; k++) @(posedge clk_sys);
        `CHK(k > TMO - 200 && k <= TMO, 1'b1)
        `CHK({busy, scl_oe, sda_oe}, 3'h0)
        itp_ctl_model_i.stop_cond();
        read_at(8'h0c, 1);
        report_and_stop();
    end
endmodule : itp_i2c_target_tb
